// ==== rtl/rtas_pkg.sv ====
// Package of offsets, field layouts and reset values for the remote target address slots.
package rtas_pkg;
	localparam int unsigned SLOT_FIRST      = 2;
	localparam int unsigned SLOT_COUNT      = 5;
	localparam logic [7:0]  ADDR_PHYS_2     = 8'h3b;
	localparam logic [7:0]  ADDR_PHYS_3     = 8'h3c;
	localparam logic [7:0]  ADDR_PHYS_4     = 8'h3d;
	localparam logic [7:0]  ADDR_PHYS_5     = 8'h3e;
	localparam logic [7:0]  ADDR_PHYS_6     = 8'h3f;
	localparam logic [7:0]  ADDR_ALIAS_2    = 8'h43;
	localparam logic [7:0]  ADDR_ALIAS_3    = 8'h44;
	localparam logic [7:0]  ADDR_ALIAS_4    = 8'h45;
	localparam logic [7:0]  ADDR_ALIAS_5    = 8'h46;
	localparam logic [7:0]  ADDR_ALIAS_6    = 8'h47;
	localparam logic [7:0]  ADDR_REMAP_STAT = 8'h50;
	localparam int unsigned FIELD_ADDR_LSB  = 1;
	localparam int unsigned FIELD_ADDR_MSB  = 7;
	localparam logic [6:0]  RESET_SLOT      = 7'h00;
	localparam logic [6:0]  ALIAS_DISABLED  = 7'h00;
	localparam logic [31:0] RESET_RDATA     = 32'h0000_0000;
endpackage : rtas_pkg

// ==== rtl/rtas_remap.sv ====
// Alias match and address substitution for the remote target slots.
module rtas_remap
	import rtas_pkg::*;
#(
	parameter int unsigned NSLOT = SLOT_COUNT
) (
	input  wire logic [NSLOT*7-1:0] alias_flat,
	input  wire logic [NSLOT*7-1:0] phys_flat,
	input  wire logic [6:0]         addr_in,
	output logic                    hit,
	output logic [6:0]              addr_out,
	output logic [2:0]              hit_slot
);
	always_comb begin
		hit      = 1'b0;
		addr_out = addr_in;
		hit_slot = 3'h0;
		for (int i = 0; i < NSLOT; i++) begin
			if (!hit && alias_flat[i*7 +: 7] != ALIAS_DISABLED &&
			    alias_flat[i*7 +: 7] == addr_in) begin
				hit      = 1'b1;
				addr_out = phys_flat[i*7 +: 7];
				hit_slot = 3'(i);
			end
		end
	end
endmodule : rtas_remap

// ==== rtl/rtas_slots.sv ====
// Register bank of remote target address slots 2 to 6 with alias remap, APB slave.
// Operation
// - Slots hold 7-bit address, bits 7:1, reset zero.
// - Slot value is the far-side physical address.
// - Alias match replaces transaction address with slot.
// - Remapped transaction goes over the control channel.
// - Alias N pairs with slot N; consecutive offsets.
// - Zero alias disables its slot entirely.
//
// Added by the designer: the APB register port.
module rtas_slots
	import rtas_pkg::*;
#(
	parameter int unsigned NSLOT = SLOT_COUNT
) (
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	input  wire logic        clk_en,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	input  wire logic        txn_valid,
	input  wire logic [6:0]  txn_addr,
	input  wire logic        txn_rnw,
	output logic             chan_valid,
	output logic [6:0]       chan_addr,
	output logic             chan_rnw,
	output logic             local_valid,
	output logic [6:0]       local_addr,
	output logic             local_rnw
);
	logic [6:0]         phys_q  [NSLOT];
	logic [6:0]         phys_d  [NSLOT];
	logic [6:0]         alias_q [NSLOT];
	logic [6:0]         alias_d [NSLOT];
	logic [31:0]        prdata_q;
	logic [31:0]        prdata_d;
	logic               perr_q;
	logic               perr_d;
	logic               ld_q;
	logic               ld_d;
	logic               cv_q;
	logic               cv_d;
	logic               lv_q;
	logic               lv_d;
	logic               rnw_q;
	logic               rnw_d;
	logic [6:0]         ca_q;
	logic [6:0]         ca_d;
	logic [6:0]         la_q;
	logic [6:0]         la_d;
	logic [7:0]         hits_q;
	logic [7:0]         hits_d;
	logic [2:0]         last_q;
	logic [2:0]         last_d;
	logic [NSLOT*7-1:0] alias_flat;
	logic [NSLOT*7-1:0] phys_flat;
	logic               hit;
	logic [6:0]         remap_addr;
	logic [2:0]         hit_slot;
	logic               acc;
	logic               done;

	function automatic logic [31:0] word_addr(input logic [7:0] off);
		return {22'h0, off, 2'b00};
	endfunction : word_addr

	function automatic int slot_of(input logic [31:0] a, input logic [7:0] base);
		int r;
		r = -1;
		for (int i = 0; i < NSLOT; i++) begin
			if (a == word_addr(base + 8'(i))) begin
				r = i;
			end
		end
		return r;
	endfunction : slot_of

	always_comb begin
		for (int i = 0; i < NSLOT; i++) begin
			alias_flat[i*7 +: 7] = alias_q[i];
			phys_flat[i*7 +: 7]  = phys_q[i];
		end
	end

	rtas_remap #(.NSLOT(NSLOT)) u_remap (
		.alias_flat (alias_flat),
		.phys_flat  (phys_flat),
		.addr_in    (txn_addr),
		.hit        (hit),
		.addr_out   (remap_addr),
		.hit_slot   (hit_slot)
	);

	// One wait state lets read data and error settle in a flip-flop before ready.
	assign acc     = psel && penable;
	assign done    = acc && ld_q;
	assign pready  = ld_q && clk_en;
	assign prdata  = prdata_q;
	assign pslverr = perr_q;

	always_comb begin
		int ps;
		int as;
		ps       = slot_of(paddr, ADDR_PHYS_2);
		as       = slot_of(paddr, ADDR_ALIAS_2);
		phys_d   = phys_q;
		alias_d  = alias_q;
		prdata_d = prdata_q;
		perr_d   = perr_q;
		ld_d     = ld_q;
		if (done && pwrite && pstrb[0]) begin
			if (ps >= 0) begin
				phys_d[ps] = pwdata[FIELD_ADDR_MSB:FIELD_ADDR_LSB];
			end else if (as >= 0) begin
				alias_d[as] = pwdata[FIELD_ADDR_MSB:FIELD_ADDR_LSB];
			end
		end
		if (!psel || done) begin
			ld_d   = 1'b0;
			perr_d = 1'b0;
		end else if (acc && !ld_q) begin
			ld_d   = 1'b1;
			perr_d = 1'b0;
			if (ps >= 0) begin
				if (!pwrite) begin
					prdata_d = {24'h0, phys_q[ps], 1'b0};
				end
			end else if (as >= 0) begin
				if (!pwrite) begin
					prdata_d = {24'h0, alias_q[as], 1'b0};
				end
			end else if (paddr == word_addr(ADDR_REMAP_STAT)) begin
				if (!pwrite) begin
					prdata_d = {21'h0, last_q, hits_q};
				end
			end else begin
				perr_d = 1'b1;
				if (!pwrite) begin
					prdata_d = RESET_RDATA;
				end
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			for (int i = 0; i < NSLOT; i++) begin
				phys_q[i]  <= RESET_SLOT;
				alias_q[i] <= RESET_SLOT;
			end
			prdata_q <= RESET_RDATA;
			perr_q   <= 1'b0;
			ld_q     <= 1'b0;
		end else if (clk_en) begin
			phys_q   <= phys_d;
			alias_q  <= alias_d;
			prdata_q <= prdata_d;
			perr_q   <= perr_d;
			ld_q     <= ld_d;
		end
	end

	always_comb begin
		cv_d  = 1'b0;
		lv_d  = 1'b0;
		ca_d  = ca_q;
		la_d  = la_q;
		rnw_d = rnw_q;
		if (txn_valid) begin
			rnw_d = txn_rnw;
			if (hit) begin
				cv_d = 1'b1;
				ca_d = remap_addr;
			end else begin
				lv_d = 1'b1;
				la_d = txn_addr;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			cv_q  <= 1'b0;
			lv_q  <= 1'b0;
			ca_q  <= RESET_SLOT;
			la_q  <= RESET_SLOT;
			rnw_q <= 1'b0;
		end else if (clk_en) begin
			cv_q  <= cv_d;
			lv_q  <= lv_d;
			ca_q  <= ca_d;
			la_q  <= la_d;
			rnw_q <= rnw_d;
		end
	end

	always_comb begin
		hits_d = hits_q;
		last_d = last_q;
		if (txn_valid && hit) begin
			hits_d = hits_q + 8'h01;
			last_d = 3'(hit_slot + 3'(SLOT_FIRST));
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			hits_q <= 8'h00;
			last_q <= 3'h0;
		end else if (clk_en) begin
			hits_q <= hits_d;
			last_q <= last_d;
		end
	end

	assign chan_valid  = cv_q;
	assign chan_addr   = ca_q;
	assign chan_rnw    = rnw_q;
	assign local_valid = lv_q;
	assign local_addr  = la_q;
	assign local_rnw   = rnw_q;
endmodule : rtas_slots

// ==== testbench/rtas_far_end.sv ====
// Far-end model that takes remapped transactions off the control channel.
module rtas_far_end (
	input  wire logic       clk_sys,
	input  wire logic       chan_valid,
	input  wire logic [6:0] chan_addr,
	output int              taken,
	output logic [6:0]      last_addr
);
	timeunit 1ns;
	timeprecision 100ps;
	initial taken = 0;
	initial last_addr = 7'h00;
	always @(posedge clk_sys) begin
		if (chan_valid === 1'b1) begin
			taken     <= taken + 1;
			last_addr <= chan_addr;
		end
	end
endmodule : rtas_far_end

// ==== testbench/rtas_slots_properties.sv ====
// Checker of read data and remap routing for the slots.
module rtas_slots_properties
	import rtas_pkg::*;
#(
	parameter int unsigned NSLOT = SLOT_COUNT
) (
	input wire logic        clk_sys,
	input wire logic        reset_n,
	input wire logic        clk_en,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic        pready,
	input wire logic [31:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	input wire logic        txn_valid,
	input wire logic [6:0]  txn_addr,
	input wire logic        chan_valid,
	input wire logic        local_valid,
	input wire logic [6:0]  local_addr
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [31:0] PHYS_LO  = {22'h0, ADDR_PHYS_2, 2'b00};
	localparam logic [31:0] PHYS_HI  = PHYS_LO + 32'(4 * (NSLOT - 1));
	localparam logic [31:0] ALIAS_LO = {22'h0, ADDR_ALIAS_2, 2'b00};
	localparam logic [31:0] ALIAS_HI = ALIAS_LO + 32'(4 * (NSLOT - 1));
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	sequence take_s;
		txn_valid && clk_en;
	endsequence
	sequence slot_rd_s;
		psel && penable && pready && !pwrite &&
		((paddr >= PHYS_LO && paddr <= PHYS_HI) || (paddr >= ALIAS_LO && paddr <= ALIAS_HI));
	endsequence
	bit0_zero_a: assert property (slot_rd_s |-> prdata[0] == 1'b0)
		else $error("slot read bit 0 set");
	upper_zero_a: assert property (slot_rd_s |-> prdata[31:8] == 24'h0)
		else $error("slot read upper bits set");
	one_route_a: assert property (take_s |=> chan_valid != local_valid) else $error("route");
	no_txn_a: assert property (!txn_valid && clk_en |=> !local_valid && !chan_valid)
		else $error("idle");
	pass_addr_a: assert property (take_s ##1 local_valid |-> local_addr == $past(txn_addr))
		else $error("laddr");
	zero_alias_a: assert property (take_s ##0 txn_addr == 7'h00 |=> local_valid && !chan_valid)
		else $error("zero");
	unmapped_err_a: assert property (psel && penable && pready && paddr == 32'h0 |-> pslverr)
		else $error("err");
	access_wait_a: assert property (psel && penable && !$past(penable) |-> !pready)
		else $error("no wait state");
endmodule : rtas_slots_properties
bind rtas_slots rtas_slots_properties #(.NSLOT(NSLOT)) i_props (.clk_sys, .reset_n, .clk_en, .psel,
	.penable, .pwrite, .pready, .paddr, .prdata, .pslverr, .txn_valid, .txn_addr, .chan_valid,
	.local_valid, .local_addr);

// ==== testbench/tb_rtas_slots.sv ====
// Self-checking bench for the remote target address slots.
module tb_rtas_slots import rtas_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk_sys = 1'b0, reset_n = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0;
	logic        pwrite = 1'b0, txn_valid = 1'b0, txn_rnw = 1'b0, e, pready, pslverr;
	logic        chan_valid, local_valid, chan_rnw, local_rnw;
	logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, r, d;
	logic [6:0]  txn_addr = 7'h00, chan_addr, local_addr, far_addr;
	int          fails = 0, checks = 0, seed = 32'h392c, taken, hits = 0, last = 0;
	int          phys[7];
	int          exp_q[$];
	rtas_slots i_rtas_slots (.clk_sys, .reset_n, .clk_en(ce), .psel, .penable, .pwrite,
		.paddr, .pwdata, .pstrb(4'hf), .pready, .prdata, .pslverr, .txn_valid, .txn_addr,
		.txn_rnw, .chan_valid, .chan_addr, .chan_rnw, .local_valid, .local_addr, .local_rnw);
	rtas_far_end i_rtas_far_end (.clk_sys, .chan_valid, .chan_addr, .taken,
		.last_addr(far_addr));
	initial forever #12.5 clk_sys = ~clk_sys;
	task automatic cmp(input string s, input logic [31:0] x, y);
		checks++;
		if (x !== y) begin
			fails++;
			$display("BAD %s exp %h got %h", s, x, y);
		end
	endtask : cmp
	task automatic end_of_test;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : end_of_test
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] dd);
		int n;
		n = 0;
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= dd;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1) begin
			n++;
			if (n > 50) begin
				fails++;
				end_of_test;
			end
			@(posedge clk_sys);
		end
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask : apb
	task automatic txn(input logic [6:0] a, input int x, input logic rw);
		txn_valid <= 1'b1;
		txn_addr  <= a;
		txn_rnw   <= rw;
		@(posedge clk_sys);
		txn_valid <= 1'b0;
		@(posedge clk_sys);
		cmp("chan", x >= 0, chan_valid);
		cmp("local", x == -1, local_valid);
		if (x >= 0) begin
			cmp("caddr", phys[x], chan_addr);
			cmp("crnw", rw, chan_rnw);
			exp_q.push_back(phys[x]);
			hits++;
			last = x;
		end else if (x == -1) begin
			cmp("laddr", a, local_addr);
			cmp("lrnw", rw, local_rnw);
		end
	endtask : txn
	initial begin
		#100us;
		fails++;
		end_of_test;
	end
	initial begin
		repeat (20) @(posedge clk_sys);
		reset_n <= 1'b1;
		for (int i = 2; i < 7; i++) begin
			apb(1'b0, (ADDR_PHYS_2 + i - 2) * 4, 32'h0);
			cmp("reset", 32'h0, r);
			d = $random(seed);
			phys[i] = d[7:1];
			apb(1'b1, (ADDR_PHYS_2 + i - 2) * 4, d);
			apb(1'b0, (ADDR_PHYS_2 + i - 2) * 4, 32'h0);
			cmp("slot", phys[i] << 1, r);
			apb(1'b1, (ADDR_ALIAS_2 + i - 2) * 4, i == 6 ? 0 : (8'h10 + i) << 1);
		end
		for (int i = 2; i < 6; i++) begin
			d = $random(seed);
			txn(7'(8'h10 + i), i, d[0]);
		end
		txn(7'h16, -1, d[1]);
		txn(7'h00, -1, d[2]);
		ce <= 1'b0;
		txn(7'h12, -2, d[3]);
		ce <= 1'b1;
		apb(1'b0, ADDR_REMAP_STAT * 4, 32'h0);
		cmp("stat", {21'h0, 3'(last), 8'(hits)}, r);
		apb(1'b1, 32'h0, 32'h0);
		cmp("err", 32'h1, e);
		cmp("far", exp_q.size(), taken);
		cmp("faraddr", exp_q[$], far_addr);
		reset_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		reset_n <= 1'b1;
		apb(1'b0, ADDR_PHYS_2 * 4, 32'h0);
		cmp("reset2", 32'h0, r);
		end_of_test;
	end
endmodule : tb_rtas_slots
